// [hw/phy_regs_pkg.sv]
// Package: register indices, field positions, reset values, timing counts
// and carrier structs for the vendor status and interrupt register group.
// Assumes a management frame engine on the same clock presents accesses.
package phy_regs_pkg;

   // Register indices on the management port
   localparam logic [4:0] REG_XOVER = 5'h1b;
   localparam logic [4:0] REG_FLAGS = 5'h1d;
   localparam logic [4:0] REG_MASK  = 5'h1e;
   localparam logic [4:0] REG_LINK  = 5'h1f;

   // Field positions
   localparam int XOVER_AUTO_DIS_BIT = 15;
   localparam int XOVER_MAN_SWAP_BIT = 13;
   localparam int XOVER_POL_BIT      = 4;
   localparam int FLAG_LO            = 1;
   localparam int FLAG_HI            = 7;
   localparam int FLAG_ENERGY_BIT    = 7;
   localparam int LINK_DONE_BIT      = 12;
   localparam int LINK_RESV_LO       = 5;
   localparam int LINK_RESV_HI       = 11;
   localparam int LINK_SPEED_LO      = 2;
   localparam int LINK_SPEED_HI      = 4;

   // Reset values
   localparam logic [6:0] MASK_RST      = 7'h00;
   localparam logic [6:0] LINK_RESV_RST = 7'h02;

   // Resolved speed and duplex codes
   localparam logic [2:0] SPD_10_HALF  = 3'h1;
   localparam logic [2:0] SPD_10_FULL  = 3'h5;
   localparam logic [2:0] SPD_100_HALF = 3'h2;
   localparam logic [2:0] SPD_100_FULL = 3'h6;

   // Timing
   localparam int CLK_KHZ          = 40000;
   localparam int ENERGY_WINDOW_MS = 256;
   localparam int ENERGY_WINDOW_CYC = ENERGY_WINDOW_MS * CLK_KHZ;
   localparam int ENERGY_CNT_W      = 24;

   typedef logic [FLAG_HI:FLAG_LO] src_t;

   // One register access from the management frame engine
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [4:0]  index;
      logic [15:0] wdata;
   } acc_req_s;

   // Event pulses from the line-side logic, one per flag bit 6:1 (bit 7 comes from energy)
   typedef struct packed {
      logic anc_done;
      logic remote_fault;
      logic link_down;
      logic partner_ack;
      logic pd_fault;
      logic page_rx;
   } line_ev_s;

endpackage : phy_regs_pkg

// [hw/flag_latch.sv]
// Latched interrupt source flags, cleared by a host read of the register.
// Assumes set pulses and the read strobe come from the same clock domain.
module flag_latch
(
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire phy_regs_pkg::src_t   set,
   input  wire logic                 rd_clr,
   output phy_regs_pkg::src_t        flags
);

   typedef struct packed {
      phy_regs_pkg::src_t flags;
   } latch_s;

   latch_s st_q;
   latch_s st_d;

   // Flags returned by a read drop; a new event in that cycle still sets
   // RL4 RL5 RL6 RL7 RL8 RL9 RL10 flags set
   // RL17 clear on read
   always_comb
   begin
      st_d = st_q;
      if (rd_clr)
      begin
         st_d.flags = '0;
      end
      st_d.flags = st_d.flags | set;
   end

   // State register
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign flags = st_q.flags;

   // RL5 RL6 RL10 event latches
   chk_flag_set_hold: assert property ( // RL5
      @(posedge mclk) disable iff (!reset_n)
      (set != '0) |=> ((flags & $past(set)) == $past(set)))
      else $error("event did not latch its flag");

   // RL17 clear on read
   chk_read_clear: assert property ( // RL17
      @(posedge mclk) disable iff (!reset_n)
      rd_clr |=> (flags == $past(set)))
      else $error("read did not clear returned flags");

   // RL17 flag holds
   chk_flag_sticky: assert property ( // RL17
      @(posedge mclk) disable iff (!reset_n)
      (!rd_clr && flags[1]) |=> flags[1])
      else $error("flag dropped without a read");

endmodule : flag_latch

// [hw/phy_vendor_status_irq_regs.sv]
// Vendor status and interrupt registers of a 10/100 transceiver: crossover
// control, polarity status, latched interrupt flags with mask, link status.
// Assumes the management frame engine and line logic share mclk.
//
// Function
// RL1: Bit 15 set disables automatic pair crossover
// RL2: Bit 13 picks straight or swapped pairs
// RL3: Read-only bit reports reversed receive polarity
// RL4: Energy event latches flag bit 7
// RL5: Negotiation complete latches flag bit 6
// RL6: Remote fault latches flag bit 5
// RL7: Link down latches flag bit 4
// RL8: Partner acknowledge latches flag bit 3
// RL9: Parallel detect fault latches flag bit 2
// RL10: Page received latches flag bit 1
// RL11: Mask bits 7:1 enable sources, reset zero
// RL12: Bit 12 reads one once negotiation done
// RL13: Host writes bits 11:5 as 0000010b
// RL14: Bits 4:2 report resolved speed and duplex
// RL15: Mode bit picks primary or alternate interrupts
// RL16: Energy indication drops after 256 ms quiet
// RL17: Flags stay set until host read clears
// RL18: Interrupt while any enabled flag set
module phy_vendor_status_irq_regs
#(
   parameter int ENERGY_CYC = phy_regs_pkg::ENERGY_WINDOW_CYC
)
(
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire phy_regs_pkg::acc_req_s acc,
   output logic [15:0]                 acc_rdata,
   input  wire phy_regs_pkg::line_ev_s ev,
   input  wire logic                   line_energy,
   input  wire logic                   auto_mdix_sel,
   input  wire logic                   rx_polarity_reversed,
   input  wire logic                   autoneg_done,
   input  wire logic [2:0]             resolved_speed_duplex,
   input  wire logic                   alternate_irq_scheme,
   output logic                        auto_crossover_disable,
   output logic                        pair_swap,
   output logic                        energy_present,
   output logic                        irq
);

   typedef struct packed {
      logic                                  auto_dis;
      logic                                  man_swap;
      logic                                  pair_swap;
      logic [6:0]                            link_resv;
      phy_regs_pkg::src_t                    mask;
      logic [15:0]                           rdata;
      logic                                  irq;
      logic                                  alt_hold;
      logic                                  energy;
      logic [phy_regs_pkg::ENERGY_CNT_W-1:0] energy_cnt;
   } regs_s;

   localparam logic [phy_regs_pkg::ENERGY_CNT_W-1:0] ENERGY_LAST =
      phy_regs_pkg::ENERGY_CNT_W'(ENERGY_CYC - 1);

   regs_s              st_q;
   regs_s              st_d;
   phy_regs_pkg::src_t flags;
   phy_regs_pkg::src_t ev_set;
   logic               rd_flags;
   logic               mask_wr;

   // Access decode shared by reads and writes
   function automatic logic hit(input logic [4:0] idx,
                                input logic [4:0] target);
      hit = (idx == target);
   endfunction : hit

   assign rd_flags = acc.rd && hit(acc.index, phy_regs_pkg::REG_FLAGS);
   assign mask_wr  = acc.wr && hit(acc.index, phy_regs_pkg::REG_MASK);

   // RL4 energy rising edge
   assign ev_set = {st_d.energy & ~st_q.energy, ev.anc_done,
                    ev.remote_fault, ev.link_down, ev.partner_ack,
                    ev.pd_fault, ev.page_rx};

   flag_latch u_flags
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .set     (ev_set),
      .rd_clr  (rd_flags),
      .flags   (flags)
   );

   // Register writes, read data, crossover, energy timer and interrupt
   always_comb
   begin
      st_d = st_q;
      // Writes
      if (acc.wr && hit(acc.index, phy_regs_pkg::REG_XOVER))
      begin
         st_d.auto_dis = acc.wdata[phy_regs_pkg::XOVER_AUTO_DIS_BIT];
         st_d.man_swap = acc.wdata[phy_regs_pkg::XOVER_MAN_SWAP_BIT];
      end
      if (mask_wr)
      begin
         st_d.mask = acc.wdata[phy_regs_pkg::FLAG_HI:phy_regs_pkg::FLAG_LO];
      end
      // RL13 reserved pattern
      if (acc.wr && hit(acc.index, phy_regs_pkg::REG_LINK))
      begin
         st_d.link_resv =
            acc.wdata[phy_regs_pkg::LINK_RESV_HI:phy_regs_pkg::LINK_RESV_LO];
      end
      // Reads; unmapped indices return zero
      if (acc.rd)
      begin
         st_d.rdata = 16'h0000;
         unique case (acc.index)
            phy_regs_pkg::REG_XOVER:
            begin
               // RL3 polarity status
               st_d.rdata[phy_regs_pkg::XOVER_AUTO_DIS_BIT] = st_q.auto_dis;
               st_d.rdata[phy_regs_pkg::XOVER_MAN_SWAP_BIT] = st_q.man_swap;
               st_d.rdata[phy_regs_pkg::XOVER_POL_BIT] = rx_polarity_reversed;
            end
            phy_regs_pkg::REG_FLAGS:
            begin
               st_d.rdata[phy_regs_pkg::FLAG_HI:phy_regs_pkg::FLAG_LO] = flags;
            end
            phy_regs_pkg::REG_MASK:
            begin
               // RL11 mask readback
               st_d.rdata[phy_regs_pkg::FLAG_HI:phy_regs_pkg::FLAG_LO] =
                  st_q.mask;
            end
            phy_regs_pkg::REG_LINK:
            begin
               // RL12 RL14 link status
               st_d.rdata[phy_regs_pkg::LINK_DONE_BIT] = autoneg_done;
               st_d.rdata[phy_regs_pkg::LINK_RESV_HI:
                          phy_regs_pkg::LINK_RESV_LO] = st_q.link_resv;
               st_d.rdata[phy_regs_pkg::LINK_SPEED_HI:
                          phy_regs_pkg::LINK_SPEED_LO] = resolved_speed_duplex;
            end
            default:
            begin
               st_d.rdata = 16'h0000;
            end
         endcase
      end
      // RL1 RL2 pair selection
      st_d.pair_swap = st_q.auto_dis ? st_q.man_swap : auto_mdix_sel;
      // RL16 energy window
      if (line_energy)
      begin
         st_d.energy     = 1'b1;
         st_d.energy_cnt = '0;
      end
      else if (st_q.energy_cnt == ENERGY_LAST)
      begin
         st_d.energy = 1'b0;
      end
      else
      begin
         st_d.energy_cnt = st_q.energy_cnt + 1'b1;
      end
      // RL15 alternate hold, cleared by a mask write; a source still wins
      if (mask_wr)
      begin
         st_d.alt_hold = 1'b0;
      end
      if ((flags & st_q.mask) != '0)
      begin
         st_d.alt_hold = 1'b1;
      end
      // RL18 RL15 interrupt output
      st_d.irq = alternate_irq_scheme ? st_q.alt_hold
                                      : ((flags & st_q.mask) != '0);
   end

   // State register; energy indication comes up set
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q           <= '0;
         st_q.mask      <= phy_regs_pkg::MASK_RST;
         st_q.link_resv <= phy_regs_pkg::LINK_RESV_RST;
         st_q.energy    <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign acc_rdata              = st_q.rdata;
   assign auto_crossover_disable = st_q.auto_dis;
   assign pair_swap              = st_q.pair_swap;
   assign energy_present         = st_q.energy;
   assign irq                    = st_q.irq;

   // RL1 manual pair path
   chk_cross_manual: assert property ( // RL1
      @(posedge mclk) disable iff (!reset_n)
      st_q.auto_dis |=> (pair_swap == $past(st_q.man_swap)))
      else $error("manual pair select not followed");

   // RL2 automatic pair path
   chk_cross_auto: assert property ( // RL2
      @(posedge mclk) disable iff (!reset_n)
      !st_q.auto_dis |=> (pair_swap == $past(auto_mdix_sel)))
      else $error("automatic pair select not followed");

   // RL3 polarity readback
   chk_polarity_read: assert property ( // RL3
      @(posedge mclk) disable iff (!reset_n)
      (acc.rd && acc.index == phy_regs_pkg::REG_XOVER)
      |=> (acc_rdata[phy_regs_pkg::XOVER_POL_BIT] ==
           $past(rx_polarity_reversed)))
      else $error("polarity bit wrong on read");

   // RL4 energy event flag
   chk_energy_flag: assert property ( // RL4
      @(posedge mclk) disable iff (!reset_n)
      $rose(energy_present) |-> flags[phy_regs_pkg::FLAG_ENERGY_BIT])
      else $error("energy event flag not latched");

   // RL12 RL14 status readback
   chk_link_read: assert property ( // RL12
      @(posedge mclk) disable iff (!reset_n)
      (acc.rd && acc.index == phy_regs_pkg::REG_LINK)
      |=> (acc_rdata[phy_regs_pkg::LINK_DONE_BIT] == $past(autoneg_done))
          && (acc_rdata[phy_regs_pkg::LINK_SPEED_HI:
                        phy_regs_pkg::LINK_SPEED_LO] ==
              $past(resolved_speed_duplex)))
      else $error("link status read wrong");

   // RL16 energy timeout
   chk_energy_drop: assert property ( // RL16
      @(posedge mclk) disable iff (!reset_n)
      (st_q.energy_cnt == ENERGY_LAST && !line_energy)
      |=> !energy_present)
      else $error("energy indication did not drop");

   // RL16 energy restore
   chk_energy_rise: assert property ( // RL16
      @(posedge mclk) disable iff (!reset_n)
      line_energy |=> energy_present)
      else $error("energy indication not set");

   // RL18 primary interrupt
   chk_irq_primary: assert property ( // RL18
      @(posedge mclk) disable iff (!reset_n)
      !alternate_irq_scheme
      |=> (irq == ($past(flags & st_q.mask) != '0)))
      else $error("primary interrupt mismatch");

   // RL15 alternate hold
   chk_irq_alt: assert property ( // RL15
      @(posedge mclk) disable iff (!reset_n)
      (alternate_irq_scheme && st_q.alt_hold && !mask_wr) ##1
      alternate_irq_scheme |=> irq)
      else $error("alternate interrupt released early");

endmodule : phy_vendor_status_irq_regs

// [bench/mgmt_host.sv]
// Management host model: issues register reads and writes to the block.
// Assumes accesses are launched 1 ns after the rising edge of mclk.
module mgmt_host
(
   input  wire logic              mclk,
   output phy_regs_pkg::acc_req_s acc
);
   timeunit 1ns;
   timeprecision 100ps;

   initial acc = '0;

   // One-cycle strobe held to its sampling edge, then scrambled fields
   task automatic access(input logic r, input logic [4:0] i,
                         input logic [15:0] d);
      @(posedge mclk);
      #1;
      acc = '{rd: r, wr: !r, index: i, wdata: d};
      @(posedge mclk);
      #1;
      acc = '{rd: 1'b0, wr: 1'b0, index: ~i, wdata: ~d};
   endtask : access

   task automatic wr(input logic [4:0] i, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (i == phy_regs_pkg::REG_LINK)
         v[11:5] = phy_regs_pkg::LINK_RESV_RST;
      access(1'b0, i, v);
   endtask : wr

   task automatic rd(input logic [4:0] i);
      access(1'b1, i, 16'h0000);
   endtask : rd
endmodule : mgmt_host

// [bench/testbench.sv]
// Self-checking bench for the vendor status and interrupt registers.
// Assumes a short energy window parameter so the quiet timeout is quick.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
   end end

   logic                   mclk, reset_n, line_energy, mdix, pol, an;
   logic                   xo_dis, swap, energy, irq, pend, alt;
   logic [2:0]             spd;
   logic [15:0]            acc_rdata;
   logic [31:0]            seed, e;
   logic [31:0]            q[$];
   logic [2:0]             codes[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
   phy_regs_pkg::line_ev_s ev;
   phy_regs_pkg::acc_req_s acc;
   int                     n_mismatch, checked, cyc;

   mgmt_host host (.mclk(mclk), .acc(acc));

   phy_vendor_status_irq_regs #(.ENERGY_CYC(16)) DUT (
      .mclk(mclk), .reset_n(reset_n), .acc(acc), .acc_rdata(acc_rdata),
      .ev(ev), .line_energy(line_energy), .auto_mdix_sel(mdix),
      .rx_polarity_reversed(pol), .autoneg_done(an),
      .resolved_speed_duplex(spd), .alternate_irq_scheme(alt),
      .auto_crossover_disable(xo_dis), .pair_swap(swap),
      .energy_present(energy), .irq(irq));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // Watcher: read data checked against the oldest note
   always @(posedge mclk) pend <= acc.rd;
   always @(negedge mclk)
      if (pend)
      begin
         e = q.pop_front();
         `CHK("acc_rdata", e[15:0], acc_rdata & e[31:16])
      end

   task automatic rd_exp(input logic [4:0] i, input logic [15:0] x,
                         input logic [15:0] m);
      q.push_back({m, x & m});
      host.rd(i);
   endtask : rd_exp

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   initial
   begin
      {reset_n, mdix, pol, an, alt} = '0;
      line_energy = 1'b1;
      spd = 3'h1;
      ev = '0;
      seed = 32'h7e1e6603;
      tick(4);
      reset_n = 1'b1;
      // Reset values
      `CHK("energy", 1'b1, energy)
      `CHK("xo_dis", 1'b0, xo_dis)
      rd_exp(5'h1b, 16'h0000, 16'hffff);
      rd_exp(5'h1d, 16'h0000, 16'hffff);
      rd_exp(5'h1e, 16'h0000, 16'hffff);
      rd_exp(5'h1f, 16'h0044, 16'hffff);
      rd_exp(5'h00, 16'h0000, 16'hffff);
      $display("test reset done");
      // Crossover control, manual select beats automatic choice
      mdix = 1'b1;
      pol = 1'b1;
      host.wr(5'h1b, 16'hdfff);
      tick(1);
      `CHK("xo_dis", 1'b1, xo_dis)
      `CHK("swap", 1'b0, swap)
      rd_exp(5'h1b, 16'h8010, 16'hffff);
      host.wr(5'h1b, 16'h2000);
      tick(1);
      `CHK("swap_auto", 1'b1, swap)
      host.wr(5'h1b, 16'ha000);
      mdix = 1'b0;
      tick(1);
      `CHK("swap_man", 1'b1, swap)
      $display("test crossover done");
      // Each line event latches its own flag
      host.wr(5'h1e, 16'h00fe);
      host.wr(5'h1d, 16'hffff);
      rd_exp(5'h1d, 16'h0000, 16'hffff);
      for (int k = 0; k < 6; k++)
      begin
         ev = phy_regs_pkg::line_ev_s'(6'h01 << k);
         tick(1);
         ev = '0;
         tick(3);
         `CHK("irq_on", 1'b1, irq)
         rd_exp(5'h1d, 16'h0002 << k, 16'hffff);
         tick(2);
         `CHK("irq_off", 1'b0, irq)
         rd_exp(5'h1d, 16'h0000, 16'hffff);
      end
      $display("test flags done");
      // Random masks against all six line event sources at once
      repeat (4)
      begin
         seed = xs(seed);
         host.wr(5'h1e, {8'h00, seed[7:0]});
         ev = '1;
         tick(1);
         ev = '0;
         tick(3);
         `CHK("irq_mask", |seed[6:1], irq)
         rd_exp(5'h1d, 16'h007e, 16'hffff);
         rd_exp(5'h1e, {8'h00, seed[7:1], 1'b0}, 16'hffff);
      end
      $display("test mask done");
      // Quiet line drops energy, its return sets flag 7
      host.wr(5'h1e, 16'h0080);
      line_energy = 1'b0;
      tick(15);
      `CHK("energy_hold", 1'b1, energy)
      tick(5);
      `CHK("energy_low", 1'b0, energy)
      line_energy = 1'b1;
      tick(4);
      `CHK("energy_hi", 1'b1, energy)
      `CHK("irq_energy", 1'b1, irq)
      rd_exp(5'h1d, 16'h0080, 16'hffff);
      $display("test energy done");
      // Speed codes and negotiation done
      host.wr(5'h1f, 16'hffff);
      for (int k = 0; k < 4; k++)
      begin
         spd = codes[k];
         an = k[0];
         tick(1);
         rd_exp(5'h1f, {3'h0, an, 7'h00, spd, 2'h0}, 16'hf01f);
      end
      $display("test status done");
      // Alternate scheme holds the interrupt until a mask write
      host.wr(5'h1e, 16'h0002);
      alt = 1'b1;
      tick(2);
      `CHK("irq_alt_idle", 1'b0, irq)
      ev.page_rx = 1'b1;
      tick(1);
      ev = '0;
      tick(3);
      `CHK("irq_alt_on", 1'b1, irq)
      rd_exp(5'h1d, 16'h0002, 16'hffff);
      tick(3);
      `CHK("irq_alt_hold", 1'b1, irq)
      host.wr(5'h1e, 16'h0000);
      tick(2);
      `CHK("irq_alt_off", 1'b0, irq)
      alt = 1'b0;
      $display("test alternate done");
      tick(2);
      report_and_stop();
   end
endmodule : testbench
